// ### hdl/pbs_indicator.sv
// LED indication engine: n flashes at a default period, or blinking for a cue.
// Assumes tick_in is a one-cycle pulse every timer step from the same clock.
`timescale 1ns/1ps
module pbs_indicator (
    // Clock and reset
    input  logic       core_clk_in,
    input  logic       rst_n_in,
    // Control
    input  logic       tick_in,
    input  logic       start_in,
    input  logic [1:0] sel_in,
    input  logic       cue_mode_in,
    input  logic       cue_done_in,
    input  logic       cont_in,
    // Status
    output logic       led_out,
    output logic       busy_out,
    output logic       done_out
);
    import pbs_pkg::*;

    logic        busy_reg, busy_next;
    logic        cue_reg, cue_next;
    logic [1:0]  sel_reg, sel_next;
    logic [3:0]  phase_reg, phase_next;
    logic [15:0] cnt_reg, cnt_next;
    logic        led_reg, led_next;
    logic        done_reg, done_next;
    logic [15:0] half;

    always_comb begin
        busy_next  = busy_reg;
        cue_next   = cue_reg;
        sel_next   = sel_reg;
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        led_next   = led_reg;
        done_next  = 1'b0;
        half       = cue_reg ? 16'(CUE_TICKS / 2) : (LS_TICKS[sel_reg] >> 1);
        if (!busy_reg) begin
            half = 16'(LS1_TICKS / 2);
        end
        if (start_in) begin
            busy_next  = 1'b1;
            cue_next   = cue_mode_in;
            sel_next   = sel_in;
            phase_next = {1'b0, sel_in, 1'b1};
            cnt_next   = '0;
            led_next   = 1'b1;
        end else if (busy_reg && cue_reg && cue_done_in) begin
            // A cue sets the length; the flash count is not checked in cue mode
            busy_next = 1'b0;
            led_next  = 1'b0;
            done_next = 1'b1;
        end else if (tick_in && (busy_reg || cont_in)) begin
            if (cnt_reg >= half - 16'h1) begin
                cnt_next = '0;
                if (busy_reg && !cue_reg && phase_reg == 4'h0) begin
                    busy_next = 1'b0;
                    led_next  = 1'b0;
                    done_next = 1'b1;
                end else begin
                    phase_next = phase_reg - 4'h1;
                    led_next   = ~led_reg;
                end
            end else begin
                cnt_next = cnt_reg + 16'h1;
            end
        end else if (!busy_reg && !cont_in) begin
            led_next = 1'b0;
            cnt_next = '0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_reg  <= 1'b0;
            cue_reg   <= 1'b0;
            sel_reg   <= CUE_1;
            phase_reg <= '0;
            cnt_reg   <= '0;
            led_reg   <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            busy_reg  <= busy_next;
            cue_reg   <= cue_next;
            sel_reg   <= sel_next;
            phase_reg <= phase_next;
            cnt_reg   <= cnt_next;
            led_reg   <= led_next;
            done_reg  <= done_next;
        end
    end

    assign led_out  = led_reg;
    assign busy_out = busy_reg;
    assign done_out = done_reg;
endmodule

// ### hdl/pbs_pkg.sv
// Constants, types and carriers for the push-button message sequencer.
// Assumes one 200 MHz clock and a message engine that plays, records and erases.
// How it works
// [R01] Record press, no cue 1: LED on
// [R02] Record press, cue 1: cue, then LED on
// [R03] Record end: LED off, or cue 2 first
// [R04] Record press ignored during other operations
// [R05] Play pulse plays; second pulse stops it
// [R06] Held play loops with forward after each
// [R07] Play release finishes current message only
// [R08] Loop blinks once, twice after last message
// [R09] Loop plays cue 1, cue 2 after last
// [R10] Play press ignored during other operations
// [R11] Idle forward advances, one flash, cue 1
// [R12] Idle forward at last wraps, two flashes
// [R13] Forward while playing advances, then plays on
// [R14] Forward on last message wraps, then plays
// [R15] Forward ignored while erasing or recording
// [R16] Erase first or last: erase, two flashes
// [R17] Erase middle message: three flashes, keep pointer
// [R18] Erase during playback stops it first
// [R19] Erase held past threshold: global erase
// [R20] No cues: warning blinks, abandon before third
// [R21] Cues: cue 1 thrice, erase, then cue 4
// [R22] Erase ignored in record and forward
// [R23] No new command while indication runs
package pbs_pkg;

    localparam int MSG_W       = 8;
    localparam int CLK_MHZ     = 200;
    // Base time step of all indication timers
    localparam int TICK_US     = 1000;
    localparam int TICK_CYC    = TICK_US * CLK_MHZ;

    // Default blink periods, one full flash each, and the erase hold time
    localparam int BLINK1_MS   = 200;
    localparam int BLINK2_MS   = 250;
    localparam int BLINK3_MS   = 300;
    localparam int BLINK4_MS   = 350;
    localparam int T_CUE_MS    = 100;
    localparam int T_HOLD_MS   = 2500;

    localparam int LS1_TICKS   = BLINK1_MS * 1000 / TICK_US;
    localparam int LS2_TICKS   = BLINK2_MS * 1000 / TICK_US;
    localparam int LS3_TICKS   = BLINK3_MS * 1000 / TICK_US;
    localparam int LS4_TICKS   = BLINK4_MS * 1000 / TICK_US;
    localparam int CUE_TICKS   = T_CUE_MS * 1000 / TICK_US;
    localparam int HOLD_TICKS  = T_HOLD_MS * 1000 / TICK_US;

    localparam logic [3:0][15:0] LS_TICKS = {16'(LS4_TICKS), 16'(LS3_TICKS),
                                             16'(LS2_TICKS), 16'(LS1_TICKS)};

    // Cue index; flash count of an indication is index plus one
    localparam logic [1:0] CUE_1 = 2'h0;
    localparam logic [1:0] CUE_2 = 2'h1;
    localparam logic [1:0] CUE_3 = 2'h2;
    localparam logic [1:0] CUE_4 = 2'h3;

    // Button bit positions
    localparam int B_REC   = 0;
    localparam int B_PLAY  = 1;
    localparam int B_ADV   = 2;
    localparam int B_ERASE = 3;

    localparam int WARN_LAST = 2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REC,
        ST_PLAY,
        ST_IND,
        ST_GE_HOLD,
        ST_GE_WARN
    } pbs_state_t;

    typedef struct packed {
        logic       msg_end;
        logic       mem_full;
        logic       cue_done;
        logic [3:0] cue_prog;
    } pbs_stat_t;

    typedef struct packed {
        logic             play_start;
        logic             play_stop;
        logic             rec_active;
        logic             erase_msg;
        logic             erase_all;
        logic             cue_start;
        logic [1:0]       cue_sel;
        logic [MSG_W-1:0] msg_sel;
    } pbs_cmd_t;

endpackage

// ### hdl/pbs_sequencer.sv
// Push-button message sequencer: buttons in, LED and message-engine commands out.
// Assumes debounced active-low button pins and an engine that reports message end,
// memory full and cue completion on this clock.
`timescale 1ns/1ps
module pbs_sequencer #(
    parameter int TICK_CYC = pbs_pkg::TICK_CYC
) (
    // Clock and reset
    input  logic              core_clk_in,
    input  logic              rst_n_in,
    // Buttons, active low, asynchronous
    input  logic              record_button_n_in,
    input  logic              play_button_n_in,
    input  logic              advance_button_n_in,
    input  logic              erase_button_n_in,
    // Message engine
    input  pbs_pkg::pbs_stat_t stat_in,
    output pbs_pkg::pbs_cmd_t  cmd_out,
    // Status
    output logic [pbs_pkg::MSG_W-1:0] play_ptr_out,
    output logic              led_out
);
    import pbs_pkg::*;

    logic [3:0]       btn_pin, s1_reg, s2_reg, prev_reg;
    logic [3:0]       held, press;
    logic [17:0]      tick_cnt_reg, tick_cnt_next;
    logic             tick;
    logic [11:0]      hold_reg, hold_next;
    logic             hold_done;
    pbs_state_t       st_reg, st_next, after_reg, after_next;
    logic [MSG_W-1:0] ptr_reg, ptr_next, cnt_reg, cnt_next;
    logic [1:0]       warn_reg, warn_next;
    logic             rec_reg, rec_next;
    logic             led_reg, led_next;
    pbs_cmd_t         cmd_reg, cmd_next;
    logic             ind_start, ind_led, ind_busy, ind_done, ind_cont;
    logic [1:0]       ind_sel;
    logic             adv_go, erase_go, at_first, at_last;

    assign btn_pin = {erase_button_n_in, advance_button_n_in,
                      play_button_n_in, record_button_n_in};

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_sync
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s1_reg[i]   <= 1'b1;
                    s2_reg[i]   <= 1'b1;
                    prev_reg[i] <= 1'b1;
                end else begin
                    s1_reg[i]   <= btn_pin[i];
                    s2_reg[i]   <= s1_reg[i];
                    prev_reg[i] <= s2_reg[i];
                end
            end
            assign held[i]  = ~s2_reg[i];
            assign press[i] = prev_reg[i] & ~s2_reg[i];
        end
    endgenerate

    // Timer step divider and erase hold timer
    always_comb begin
        tick          = (tick_cnt_reg == 18'(TICK_CYC - 1));
        tick_cnt_next = tick ? '0 : tick_cnt_reg + 18'h1;
        hold_done     = (hold_reg == 12'(HOLD_TICKS));
        hold_next     = hold_reg;
        if (!held[B_ERASE]) begin
            hold_next = '0;
        end else if (tick && !hold_done) begin
            hold_next = hold_reg + 12'h1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_cnt_reg <= '0;
            hold_reg     <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            hold_reg     <= hold_next;
        end
    end

    assign at_first = (ptr_reg == '0);
    assign at_last  = (cnt_reg == '0) || (ptr_reg == cnt_reg - 8'h1);

    always_comb begin
        st_next    = st_reg;
        after_next = after_reg;
        ptr_next   = ptr_reg;
        cnt_next   = cnt_reg;
        warn_next  = warn_reg;
        rec_next   = rec_reg;
        cmd_next   = '0;
        ind_start  = 1'b0;
        ind_sel    = CUE_1;
        adv_go     = 1'b0;
        erase_go   = 1'b0;
        unique case (st_reg)
            ST_IDLE: begin
                // The indication must finish before anything is taken (see [R23])
                if (!ind_busy) begin
                    if (press[B_REC]) begin
                        if (stat_in.cue_prog[CUE_1]) begin
                            ind_start  = 1'b1; // see [R02]
                            after_next = ST_REC;
                            st_next    = ST_IND;
                        end else begin
                            rec_next = 1'b1; // see [R01]
                            st_next  = ST_REC;
                        end
                    end else if (press[B_PLAY] && cnt_reg != '0) begin
                        cmd_next.play_start = 1'b1; // see [R05]
                        st_next             = ST_PLAY;
                    end else if (press[B_ADV]) begin
                        adv_go     = 1'b1; // see [R11] see [R12]
                        after_next = ST_IDLE;
                        st_next    = ST_IND;
                    end else if (press[B_ERASE]) begin
                        erase_go   = 1'b1; // see [R16] see [R17]
                        after_next = ST_GE_HOLD;
                        st_next    = ST_IND;
                    end
                end
            end
            ST_REC: begin
                // Other buttons are not looked at here (see [R10] see [R15] see [R22])
                if (!held[B_REC] || stat_in.mem_full) begin
                    rec_next = 1'b0; // see [R03]
                    cnt_next = cnt_reg + 8'h1;
                    ptr_next = cnt_reg;
                    st_next  = ST_IDLE;
                    if (stat_in.cue_prog[CUE_2]) begin
                        ind_start  = 1'b1;
                        ind_sel    = CUE_2;
                        after_next = ST_IDLE;
                        st_next    = ST_IND;
                    end
                end
            end
            ST_PLAY: begin
                // A record press is dropped while playing (see [R04])
                if (press[B_ERASE]) begin
                    cmd_next.play_stop = 1'b1; // see [R18]
                    erase_go           = 1'b1; // see [R16] see [R17]
                    after_next         = ST_GE_HOLD;
                    st_next            = ST_IND;
                end else if (press[B_ADV]) begin
                    cmd_next.play_stop = 1'b1; // see [R13] see [R14]
                    adv_go             = 1'b1;
                    after_next         = ST_PLAY;
                    st_next            = ST_IND;
                end else if (press[B_PLAY]) begin
                    cmd_next.play_stop = 1'b1; // see [R05]
                    st_next            = ST_IDLE;
                end else if (stat_in.msg_end) begin
                    if (held[B_PLAY]) begin
                        adv_go     = 1'b1; // see [R06] see [R08] see [R09]
                        after_next = ST_PLAY;
                        st_next    = ST_IND;
                    end else begin
                        st_next = ST_IDLE; // see [R07]
                    end
                end
            end
            ST_IND: begin
                // Buttons are ignored until the flashes end (see [R23])
                if (ind_done) begin
                    st_next = after_reg;
                    if (after_reg == ST_REC) begin
                        rec_next = 1'b1; // see [R02]
                    end
                    if (after_reg == ST_PLAY) begin
                        cmd_next.play_start = 1'b1; // see [R13]
                    end
                end
            end
            ST_GE_HOLD: begin
                if (!held[B_ERASE]) begin
                    st_next = ST_IDLE;
                end else if (hold_done) begin
                    warn_next = '0; // see [R19]
                    ind_start = 1'b1;
                    st_next   = ST_GE_WARN;
                end
            end
            ST_GE_WARN: begin
                // Release during the warning drops the global erase
                if (!held[B_ERASE]) begin
                    st_next = ST_IDLE; // see [R20] see [R21]
                end else if (ind_done) begin
                    if (warn_reg == 2'(WARN_LAST)) begin
                        cmd_next.erase_all = 1'b1; // see [R21]
                        cnt_next           = '0;
                        ptr_next           = '0;
                        ind_start          = 1'b1;
                        ind_sel            = CUE_4;
                        after_next         = ST_IDLE;
                        st_next            = ST_IND;
                    end else begin
                        warn_next = warn_reg + 2'h1; // see [R20]
                        ind_start = 1'b1;
                    end
                end
            end
        endcase
        if (adv_go) begin
            ind_start = 1'b1;
            if (at_last) begin
                ptr_next = '0; // see [R12] see [R14]
                ind_sel  = CUE_2;
            end else begin
                ptr_next = ptr_reg + 8'h1; // see [R11] see [R13]
                ind_sel  = CUE_1;
            end
        end
        if (erase_go) begin
            ind_start = 1'b1;
            if (cnt_reg != '0 && (at_first || at_last)) begin
                cmd_next.erase_msg = 1'b1; // see [R16]
                cnt_next           = cnt_reg - 8'h1;
                ptr_next           = at_first ? '0 : ptr_reg - 8'h1;
                ind_sel            = CUE_2;
            end else begin
                ind_sel = CUE_3; // see [R17]
            end
        end
        cmd_next.rec_active = rec_next;
        cmd_next.cue_start  = ind_start && stat_in.cue_prog[ind_sel];
        cmd_next.cue_sel    = ind_start ? ind_sel : cmd_reg.cue_sel;
        // The erase command names the message before the pointer moves
        cmd_next.msg_sel    = erase_go ? ptr_reg : ptr_next;
        led_next            = rec_reg | ind_led;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg    <= ST_IDLE;
            after_reg <= ST_IDLE;
            ptr_reg   <= '0;
            cnt_reg   <= '0;
            warn_reg  <= '0;
            rec_reg   <= 1'b0;
            led_reg   <= 1'b0;
            cmd_reg   <= '0;
        end else begin
            st_reg    <= st_next;
            after_reg <= after_next;
            ptr_reg   <= ptr_next;
            cnt_reg   <= cnt_next;
            warn_reg  <= warn_next;
            rec_reg   <= rec_next;
            led_reg   <= led_next;
            cmd_reg   <= cmd_next;
        end
    end

    assign ind_cont = (st_reg == ST_PLAY);

    pbs_indicator u_ind (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .tick_in     (tick),
        .start_in    (ind_start),
        .sel_in      (ind_sel),
        .cue_mode_in (stat_in.cue_prog[ind_sel]),
        .cue_done_in (stat_in.cue_done),
        .cont_in     (ind_cont),
        .led_out     (ind_led),
        .busy_out    (ind_busy),
        .done_out    (ind_done)
    );

    assign cmd_out      = cmd_reg;
    assign play_ptr_out = ptr_reg;
    assign led_out      = led_reg;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_rec_on;
        rec_reg ##1 led_out;
    endsequence

    sequence s_cue_out(logic [1:0] sel);
        cmd_out.cue_start && cmd_out.cue_sel == sel;
    endsequence

    property p_rec_direct;
        st_reg == ST_IDLE && !ind_busy && press[B_REC] && !stat_in.cue_prog[CUE_1]
            |=> s_rec_on;
    endproperty
    a_rec_direct: assert property (p_rec_direct) else $error("record LED late"); // see [R01]

    property p_rec_cue;
        st_reg == ST_IDLE && !ind_busy && press[B_REC] && stat_in.cue_prog[CUE_1]
            |=> !rec_reg and s_cue_out(CUE_1);
    endproperty
    a_rec_cue: assert property (p_rec_cue) else $error("record cue missing"); // see [R02]

    property p_rec_end;
        st_reg == ST_REC && !held[B_REC] && !stat_in.cue_prog[CUE_2]
            |=> !rec_reg && cnt_reg == 8'($past(cnt_reg) + 8'h1) ##1 !led_out;
    endproperty
    a_rec_end: assert property (p_rec_end) else $error("record end wrong"); // see [R03]

    property p_no_rec_in_play;
        st_reg == ST_PLAY |=> !rec_reg;
    endproperty
    a_no_rec_in_play: assert property (p_no_rec_in_play) else $error("rec in play"); // see [R04]

    property p_edge_stop;
        st_reg == ST_PLAY && press == 4'h2 |=> cmd_out.play_stop && st_reg == ST_IDLE;
    endproperty
    a_edge_stop: assert property (p_edge_stop) else $error("play not stopped"); // see [R05]

    property p_loop;
        st_reg == ST_PLAY && press == 4'h0 && stat_in.msg_end && held[B_PLAY]
            |=> st_reg == ST_IND && after_reg == ST_PLAY;
    endproperty
    a_loop: assert property (p_loop) else $error("loop forward missing"); // see [R06]

    property p_adv_step;
        st_reg == ST_IDLE && !ind_busy && press == 4'h4 && !at_last
            |=> ptr_reg == 8'($past(ptr_reg) + 8'h1) && ind_busy;
    endproperty
    a_adv_step: assert property (p_adv_step) else $error("forward step wrong"); // see [R11]

    property p_adv_wrap;
        st_reg == ST_IDLE && !ind_busy && press == 4'h4 && at_last
            |=> ptr_reg == '0 && cmd_out.cue_sel == CUE_2;
    endproperty
    a_adv_wrap: assert property (p_adv_wrap) else $error("forward wrap wrong"); // see [R12]

    property p_erase_mid;
        st_reg == ST_IDLE && !ind_busy && press == 4'h8 && !at_first && !at_last
            |=> $stable(ptr_reg) && !cmd_out.erase_msg && cmd_out.cue_sel == CUE_3;
    endproperty
    a_erase_mid: assert property (p_erase_mid) else $error("middle erase wrong"); // see [R17]

    property p_ge_start;
        st_reg == ST_GE_HOLD && held[B_ERASE] && hold_done |=> st_reg == ST_GE_WARN;
    endproperty
    a_ge_start: assert property (p_ge_start) else $error("global erase late"); // see [R19]

    property p_busy_refuse;
        st_reg == ST_IDLE && ind_busy |=> st_reg == ST_IDLE && !rec_reg;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("cmd while busy"); // see [R23]
endmodule

// ### sim/pbs_engine_model.sv
// Behavioural message engine: ends messages and cues after random delays.
// Assumes the sequencer's commands arrive on the same clock.
`timescale 1ns/1ps
module pbs_engine_model
    import pbs_pkg::*;
(
    // Clock and reset
    input  logic       core_clk_in,
    input  logic       rst_n_in,
    // Sequencer side
    input  pbs_cmd_t   cmd_in,
    input  logic [3:0] cue_prog_in,
    output pbs_stat_t  stat_out
);
    int seed = 32'h5a17c3e1;
    int play_cnt;
    int cue_cnt;
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            play_cnt <= 0;
            cue_cnt  <= 0;
            stat_out <= '0;
        end else begin
            stat_out.msg_end  <= (play_cnt == 1);
            stat_out.cue_done <= (cue_cnt == 1);
            stat_out.mem_full <= 1'b0;
            stat_out.cue_prog <= cue_prog_in;
            // A start wins over a stop so a restart is never lost
            if (cmd_in.play_start) begin
                play_cnt <= 300 + {$random(seed)} % 200;
            end else if (cmd_in.play_stop || cmd_in.erase_msg) begin
                play_cnt <= 0;
            end else if (play_cnt > 0) begin
                play_cnt <= play_cnt - 1;
            end
            if (cmd_in.cue_start) begin
                cue_cnt <= 200 + {$random(seed)} % 100;
            end else if (cue_cnt > 0) begin
                cue_cnt <= cue_cnt - 1;
            end
        end
    end
endmodule

// ### sim/pbs_sequencer_test.sv
// Self-checking bench for the push-button sequencer with a model engine.
// Assumes a shortened timer step; no cue clips are programmed.
`timescale 1ns/1ps
module pbs_sequencer_test;
    import pbs_pkg::*;
    localparam int TK = 4;
    localparam int LS = LS1_TICKS * TK;
    logic             core_clk = 1'b0;
    logic             rst_n    = 1'b0;
    logic [3:0]       btn_n    = 4'hf;
    logic [3:0]       cue_prog = 4'h0;
    pbs_stat_t        stat;
    pbs_cmd_t         cmd;
    logic [MSG_W-1:0] ptr;
    logic             led;
    logic [MSG_W-1:0] er_sel;
    int seed = 32'hd8bab029;
    int error_cnt = 0;
    int n_checks = 0;
    int n_start = 0;
    int n_stop = 0;
    int n_erase = 0;
    int n_all = 0;
    int s0;
    int s1;
    always #2.5 core_clk = ~core_clk;
    pbs_sequencer #(.TICK_CYC(TK)) i_pbs_sequencer (
        .core_clk_in        (core_clk),
        .rst_n_in           (rst_n),
        .record_button_n_in (btn_n[B_REC]),
        .play_button_n_in   (btn_n[B_PLAY]),
        .advance_button_n_in(btn_n[B_ADV]),
        .erase_button_n_in  (btn_n[B_ERASE]),
        .stat_in            (stat),
        .cmd_out            (cmd),
        .play_ptr_out       (ptr),
        .led_out            (led)
    );
    pbs_engine_model i_pbs_engine_model (
        .core_clk_in(core_clk),
        .rst_n_in   (rst_n),
        .cmd_in     (cmd),
        .cue_prog_in(cue_prog),
        .stat_out   (stat)
    );
    always @(posedge core_clk) begin
        if (cmd.play_start === 1'b1) n_start++;
        if (cmd.play_stop === 1'b1) n_stop++;
        if (cmd.erase_all === 1'b1) n_all++;
        if (cmd.erase_msg === 1'b1) begin
            n_erase++;
            er_sel = cmd.msg_sel;
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic press(input int b);
        @(negedge core_clk);
        btn_n[b] = 1'b0;
        repeat (4 + {$random(seed)} % 6) @(negedge core_clk);
        btn_n[b] = 1'b1;
    endtask
    // LED must rest low longer than any off half-flash
    task automatic quiet();
        int q;
        q = 0;
        for (int i = 0; i < 40000 && q < LS; i++) begin
            @(negedge core_clk);
            q = (led === 1'b0) ? q + 1 : 0;
        end
        if (q < LS) begin
            error_cnt++;
            print_verdict();
        end
        repeat (5 + {$random(seed)} % 20) @(negedge core_clk);
    endtask
    initial begin
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        chk("ptr reset", ptr, 0);
        chk("led reset", led, 0);
        for (int k = 0; k < 3; k++) begin
            s0 = n_start;
            btn_n[B_REC] = 1'b0;
            repeat (8) @(negedge core_clk);
            chk("rec_active", cmd.rec_active, 1);
            chk("led rec", led, 1);
            press(B_PLAY);
            press(B_ADV);
            chk("start in rec", n_start - s0, 0);
            btn_n[B_REC] = 1'b1;
            repeat (8) @(negedge core_clk);
            chk("rec end", cmd.rec_active, 0);
            chk("led rec end", led, 0);
            quiet();
            chk("ptr rec", ptr, k);
        end
        $display("test record done");
        press(B_ADV);
        repeat (300) @(negedge core_clk);
        press(B_ADV);
        quiet();
        chk("ptr wrap", ptr, 0);
        press(B_ADV);
        quiet();
        chk("ptr adv", ptr, 1);
        $display("test forward done");
        s0 = n_erase;
        press(B_ERASE);
        quiet();
        chk("erase mid", n_erase - s0, 0);
        chk("ptr mid", ptr, 1);
        $display("test erase middle done");
        s0 = n_start;
        press(B_PLAY);
        repeat (20) @(negedge core_clk);
        btn_n[B_REC] = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("rec in play", cmd.rec_active, 0);
        btn_n[B_REC] = 1'b1;
        quiet();
        chk("play once", n_start - s0, 1);
        chk("ptr play", ptr, 1);
        s0 = n_stop;
        press(B_PLAY);
        repeat (50) @(negedge core_clk);
        press(B_PLAY);
        quiet();
        chk("play stop", n_stop - s0, 1);
        chk("ptr stop", ptr, 1);
        $display("test edge play done");
        s0 = n_start;
        @(negedge core_clk);
        btn_n[B_PLAY] = 1'b0;
        for (int i = 0; i < 40000 && n_start < s0 + 2; i++) @(negedge core_clk);
        chk("loop ptr", ptr, 2);
        btn_n[B_PLAY] = 1'b1;
        quiet();
        chk("loop end ptr", ptr, 2);
        chk("loop starts", n_start - s0, 2);
        $display("test loop play done");
        s0 = n_erase;
        press(B_ERASE);
        quiet();
        chk("erase last", n_erase - s0, 1);
        chk("erase sel", er_sel, 2);
        chk("ptr erase", ptr, 1);
        press(B_ADV);
        quiet();
        chk("ptr wrap 2", ptr, 0);
        $display("test erase last done");
        s0 = n_start;
        s1 = n_stop;
        press(B_PLAY);
        repeat (50) @(negedge core_clk);
        press(B_ADV);
        quiet();
        chk("adv play stop", n_stop - s1, 1);
        chk("adv play starts", n_start - s0, 2);
        chk("adv play ptr", ptr, 1);
        $display("test advance in play done");
        s0 = n_erase;
        @(negedge core_clk);
        btn_n[B_ERASE] = 1'b0;
        for (int i = 0; i < 30000 && n_all == 0; i++) @(negedge core_clk);
        btn_n[B_ERASE] = 1'b1;
        quiet();
        chk("global erase", n_all, 1);
        chk("erase before global", n_erase - s0, 1);
        chk("ptr global", ptr, 0);
        // Release falls inside the second warning flash
        @(negedge core_clk);
        btn_n[B_ERASE] = 1'b0;
        repeat ((HOLD_TICKS + LS1_TICKS * 5 / 4) * TK) @(negedge core_clk);
        btn_n[B_ERASE] = 1'b1;
        quiet();
        chk("global abandon", n_all, 1);
        $display("test global erase done");
        print_verdict();
    end
endmodule
